// ### src/gpcfg_regs.sv
// Purpose: gigabit control/status registers and the indirect extended window
// Assumes: management frame decoder gives one-cycle rd/wr strobes with address
// Notes: read data valid two cycles after rd strobe (extended store latency)
`timescale 1ns/1ps
module gpcfg_regs
    import gpcfg_pkg::*;
#(
    parameter int EXT_DEPTH = GPCFG_EXT_DEPTH
) (
    input wire logic sys_clk, // 125 MHz clock
    input wire logic resetn, // async reset, active low
    input wire logic clk_en, // freezes all state when low
    input wire logic reg_rd, // one-cycle read strobe
    input wire logic reg_wr, // one-cycle write strobe
    input wire logic [4:0] reg_addr, // register number
    input wire logic [15:0] reg_wdata, // write data
    output logic [15:0] reg_rdata, // read data
    output logic reg_rvalid, // read data valid pulse
    input wire logic ms_fault, // manual master/slave fault pulse
    input wire logic ms_resolved_master, // resolved role level
    input wire logic local_rx_ok, // local receiver good
    input wire logic remote_rx_ok, // remote receiver good
    input wire logic lp_gig_fd, // partner gigabit full duplex ability
    input wire logic lp_gig_hd, // partner gigabit half duplex ability
    input wire logic idle_err, // idle error pulse
    input wire logic link_down, // link-down event pulse
    output logic [2:0] test_mode, // transmit test mode select
    output logic ms_manual_en, // manual master/slave forcing
    output logic ms_force_master, // forced role when manual
    output logic adv_multi_port, // advertise multi-port
    output logic adv_gig_fd, // advertise gigabit full duplex
    output logic adv_gig_hd, // advertise gigabit half duplex
    output logic cable_test_start // cable test start pulse
);
    localparam int EAW = $clog2(EXT_DEPTH);

    typedef struct packed {
        logic [15:0] ctrl;
        logic fault;
        logic [15:0] ind_ctrl;
        logic [GPCFG_EXT_AW-1:0] ptr;
        logic rd_pend;
        logic rd_ext;
        logic [15:0] rd_word;
        logic [15:0] rdata;
        logic rvalid;
        logic ct_start;
        logic force_m;
    } gpcfg_regs_s;

    gpcfg_regs_s st_r, st_nxt;
    logic [7:0] ierr_count;
    logic [15:0] ext_rdata;
    logic ext_we;
    logic ierr_clr;
    logic ind_ok;
    gpcfg_func_e func;

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic logic hit(input logic [4:0] a, input logic [4:0] ofs);
        hit = (a == ofs);
    endfunction

    function automatic logic [15:0] status_word(input logic f, input logic [7:0] c);
        status_word = {f, ms_resolved_master, local_rx_ok, remote_rx_ok,
                       lp_gig_fd, lp_gig_hd, 2'h0, c};
    endfunction

    assign func = gpcfg_func_e'(st_r.ind_ctrl[GPCFG_FUNC_HI:GPCFG_FUNC_LO]);
    assign ind_ok = (st_r.ind_ctrl[4:0] == GPCFG_UNIT_ID);
    assign ierr_clr = reg_rd && hit(reg_addr, GPCFG_GIG_STAT_OFS);
    assign ext_we = reg_wr && hit(reg_addr, GPCFG_IND_DATA_OFS) && ind_ok
                    && func != GPCFG_FN_ADDR;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.rvalid = 1'b0;
        st_nxt.rd_pend = 1'b0;
        st_nxt.ct_start = 1'b0;
        // manual forcing selects the value bit, else keep automatic result
        st_nxt.force_m = st_r.ctrl[GPCFG_MAN_EN_BIT] ? st_r.ctrl[GPCFG_MAN_VAL_BIT]
                                                     : ms_resolved_master;
        if (link_down && st_r.ctrl[GPCFG_AUTO_CT_BIT]) begin
            st_nxt.ct_start = 1'b1;
        end
        if (reg_wr) begin
            if (hit(reg_addr, GPCFG_GIG_CTRL_OFS)) begin
                st_nxt.ctrl = reg_wdata & GPCFG_GIG_CTRL_WMASK;
            end
            if (hit(reg_addr, GPCFG_IND_CTRL_OFS)) begin
                st_nxt.ind_ctrl = reg_wdata & GPCFG_IND_CTRL_WMASK;
            end
            if (hit(reg_addr, GPCFG_IND_DATA_OFS) && ind_ok) begin
                case (func)
                    GPCFG_FN_ADDR: st_nxt.ptr = reg_wdata;
                    GPCFG_FN_DATA: st_nxt.ptr = st_r.ptr;
                    GPCFG_FN_INC_RW, GPCFG_FN_INC_W: begin
                        st_nxt.ptr = st_r.ptr + 16'h0001;
                    end
                    default: st_nxt.ptr = st_r.ptr;
                endcase
            end
        end
        if (reg_rd) begin
            st_nxt.rd_pend = 1'b1;
            st_nxt.rd_ext = 1'b0;
            // snapshot held apart from rdata so a back-to-back read
            // cannot overwrite the answer still in flight
            st_nxt.rd_word = 16'h0000;
            case (reg_addr)
                GPCFG_GIG_CTRL_OFS: st_nxt.rd_word = st_r.ctrl;
                GPCFG_GIG_STAT_OFS: begin
                    st_nxt.rd_word = status_word(st_r.fault, ierr_count);
                end
                GPCFG_IND_CTRL_OFS: st_nxt.rd_word = st_r.ind_ctrl;
                GPCFG_IND_DATA_OFS: begin
                    if (!ind_ok) begin
                        st_nxt.rd_word = 16'h0000;
                    end else if (func == GPCFG_FN_ADDR) begin
                        st_nxt.rd_word = st_r.ptr;
                    end else begin
                        st_nxt.rd_ext = 1'b1;
                        if (func == GPCFG_FN_INC_RW) begin
                            st_nxt.ptr = st_r.ptr + 16'h0001;
                        end
                    end
                end
                default: st_nxt.rd_word = 16'h0000;
            endcase
        end
        // a fault in the clearing-read cycle stays latched
        if (ierr_clr) begin
            st_nxt.fault = 1'b0;
        end
        if (ms_fault) begin
            st_nxt.fault = 1'b1;
        end
        // second stage: extended store data is ready now
        if (st_r.rd_pend) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata = st_r.rd_ext ? ext_rdata : st_r.rd_word;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= '0;
            st_r.ctrl <= GPCFG_GIG_CTRL_RST;
        end else if (clk_en) begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // submodules
    // ------------------------------------------------------------
    gpcfg_ierr_cnt #(
        .W(GPCFG_IERR_W)
    ) u_ierr (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .clk_en(clk_en),
        .err(idle_err),
        .clr(ierr_clr),
        .count(ierr_count)
    );

    // pointer address is sampled in the strobe cycle, before increment
    gpcfg_ext_mem #(
        .DEPTH(EXT_DEPTH)
    ) u_ext (
        .sys_clk(sys_clk),
        .clk_en(clk_en),
        .we(ext_we),
        .addr(st_r.ptr[EAW-1:0]),
        .wdata(reg_wdata),
        .rdata(ext_rdata)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign reg_rdata = st_r.rdata;
    assign reg_rvalid = st_r.rvalid;
    assign test_mode = st_r.ctrl[GPCFG_TM_HI:GPCFG_TM_LO];
    assign ms_manual_en = st_r.ctrl[GPCFG_MAN_EN_BIT];
    assign ms_force_master = st_r.force_m;
    assign adv_multi_port = st_r.ctrl[GPCFG_PORT_BIT];
    assign adv_gig_fd = st_r.ctrl[GPCFG_ADV_FD_BIT];
    assign adv_gig_hd = st_r.ctrl[GPCFG_ADV_HD_BIT];
    assign cable_test_start = st_r.ct_start;
endmodule

// ### src/gpcfg_pkg.sv
// Purpose: constants for the gigabit management register slice
// Assumes: 16-bit management registers addressed by a 5-bit register number
// Notes: field positions and reset values shared by all design files
package gpcfg_pkg;
    localparam logic [4:0] GPCFG_GIG_CTRL_OFS = 5'h09;
    localparam logic [4:0] GPCFG_GIG_STAT_OFS = 5'h0a;
    localparam logic [4:0] GPCFG_IND_CTRL_OFS = 5'h0d;
    localparam logic [4:0] GPCFG_IND_DATA_OFS = 5'h0e;
    localparam logic [15:0] GPCFG_GIG_CTRL_RST = 16'h0300;
    localparam logic [15:0] GPCFG_GIG_CTRL_WMASK = 16'hff80;
    localparam logic [15:0] GPCFG_IND_CTRL_WMASK = 16'hc01f;
    localparam logic [4:0] GPCFG_UNIT_ID = 5'h1f;
    localparam int GPCFG_TM_HI = 15;
    localparam int GPCFG_TM_LO = 13;
    localparam int GPCFG_MAN_EN_BIT = 12;
    localparam int GPCFG_MAN_VAL_BIT = 11;
    localparam int GPCFG_PORT_BIT = 10;
    localparam int GPCFG_ADV_FD_BIT = 9;
    localparam int GPCFG_ADV_HD_BIT = 8;
    localparam int GPCFG_AUTO_CT_BIT = 7;
    localparam int GPCFG_FUNC_HI = 15;
    localparam int GPCFG_FUNC_LO = 14;
    localparam int GPCFG_IERR_W = 8;
    localparam int GPCFG_EXT_AW = 16;
    localparam int GPCFG_EXT_DEPTH = 32;

    typedef enum logic [1:0] {
        GPCFG_FN_ADDR = 2'h0,
        GPCFG_FN_DATA = 2'h1,
        GPCFG_FN_INC_RW = 2'h2,
        GPCFG_FN_INC_W = 2'h3
    } gpcfg_func_e;
endpackage

// ### src/gpcfg_ext_mem.sv
// Purpose: small extended register store for the indirect window
// Assumes: pointer low bits index the store, upper bits alias
// Notes: read data comes out of a register one cycle after the address
`timescale 1ns/1ps
module gpcfg_ext_mem
    import gpcfg_pkg::*;
#(
    parameter int DEPTH = GPCFG_EXT_DEPTH,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic sys_clk, // clock
    input wire logic clk_en, // freezes all state when low
    input wire logic we, // write strobe
    input wire logic [AW-1:0] addr, // word index
    input wire logic [15:0] wdata, // write data
    output logic [15:0] rdata // registered read data
);
    typedef struct packed {
        logic [DEPTH-1:0][15:0] mem;
        logic [15:0] rd;
    } gpcfg_mem_s;

    gpcfg_mem_s st_r, st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (we) begin
            st_nxt.mem[addr] = wdata;
        end
        st_nxt.rd = st_r.mem[addr];
    end

    // no reset: contents are undefined until software writes them
    always_ff @(posedge sys_clk) begin
        if (clk_en) begin
            st_r <= st_nxt;
        end
    end

    assign rdata = st_r.rd;
endmodule

// ### src/gpcfg_ierr_cnt.sv
// Purpose: saturating idle error counter with clear on read
// Assumes: error pulses one cycle each
// Notes: an error in the clearing cycle restarts the count at one
`timescale 1ns/1ps
module gpcfg_ierr_cnt
    import gpcfg_pkg::*;
#(
    parameter int W = GPCFG_IERR_W
) (
    input wire logic sys_clk, // clock
    input wire logic resetn, // async reset, active low
    input wire logic clk_en, // freezes state when low
    input wire logic err, // idle error event
    input wire logic clr, // clearing read
    output logic [W-1:0] count // current count
);
    typedef struct packed {
        logic [W-1:0] cnt;
    } gpcfg_cnt_s;

    gpcfg_cnt_s st_r, st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (clr) begin
            st_nxt.cnt = {{(W-1){1'b0}}, err};
        end else if (err && st_r.cnt != {W{1'b1}}) begin
            st_nxt.cnt = st_r.cnt + {{(W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= '0;
        end else if (clk_en) begin
            st_r <= st_nxt;
        end
    end

    assign count = st_r.cnt;
endmodule

// ### testbench/gpcfg_mgr_model.sv
// Purpose: management controller model driving the register strobes
// Assumes: strobes change on the falling edge, answer two cycles after the strobe
// Notes: released lines show the inverse of the last value
`timescale 1ns/1ps
module gpcfg_mgr_model (
    input wire logic sys_clk, // clock
    input wire logic [15:0] reg_rdata, // read data
    input wire logic reg_rvalid, // read answer
    output logic reg_rd, // read strobe
    output logic reg_wr, // write strobe
    output logic [4:0] reg_addr, // register number
    output logic [15:0] reg_wdata // write data
);
    initial begin
        reg_rd = 1'b0;
        reg_wr = 1'b0;
        reg_addr = 5'h1a;
        reg_wdata = 16'ha5c3;
    end
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(negedge sys_clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge sys_clk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
    // no answer within four cycles leaves d unknown, which never matches
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        int n;
        d = 16'hxxxx;
        n = 0;
        @(negedge sys_clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge sys_clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        while (n < 4 && reg_rvalid !== 1'b1) begin
            @(negedge sys_clk);
            n++;
        end
        if (reg_rvalid === 1'b1) d = reg_rdata;
    endtask
endmodule

// ### testbench/gpcfg_regs_properties.sv
// Purpose: port-level checks of the gigabit register slice
// Assumes: single clock domain, async active-low reset
// Notes: attached by bind below
`timescale 1ns/1ps
module gpcfg_regs_properties
    import gpcfg_pkg::*;
(
    input wire logic sys_clk, resetn, clk_en, reg_rd, reg_wr, reg_rvalid, link_down,
    input wire logic ms_manual_en, ms_force_master, ms_resolved_master, cable_test_start,
    input wire logic adv_multi_port, adv_gig_fd, adv_gig_hd, local_rx_ok, remote_rx_ok,
    input wire logic lp_gig_fd, lp_gig_hd,
    input wire logic [2:0] test_mode,
    input wire logic [4:0] reg_addr,
    input wire logic [15:0] reg_wdata, reg_rdata
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    sequence s_ctrl_wr;
        clk_en && reg_wr && reg_addr == GPCFG_GIG_CTRL_OFS;
    endsequence
    sequence s_stat_rd;
        clk_en && reg_rd && reg_addr == GPCFG_GIG_STAT_OFS;
    endsequence
    chk_read_latency: assert property (clk_en && reg_rd |-> ##2 reg_rvalid)
        else $error("read answer late");
    chk_tm_write: assert property (s_ctrl_wr |=> test_mode == $past(reg_wdata[15:13]))
        else $error("test mode not written");
    chk_adv_write: assert property (s_ctrl_wr |=>
        {ms_manual_en, adv_multi_port, adv_gig_fd, adv_gig_hd} ==
        {$past(reg_wdata[12]), $past(reg_wdata[10:8])}) else $error("control bits wrong");
    chk_adv_reset: assert property ($rose(resetn) |-> adv_gig_fd && adv_gig_hd)
        else $error("advertise reset wrong");
    chk_role_auto: assert property ($past(resetn) && $past(clk_en) &&
        !$past(ms_manual_en) |-> ms_force_master == $past(ms_resolved_master))
        else $error("automatic role wrong");
    chk_start_cause: assert property (cable_test_start |-> $past(link_down))
        else $error("cable test without link down");
    chk_stat_fields: assert property (s_stat_rd |-> ##2 reg_rvalid &&
        reg_rdata[14:8] == {$past(ms_resolved_master, 2), $past(local_rx_ok, 2),
        $past(remote_rx_ok, 2), $past(lp_gig_fd, 2), $past(lp_gig_hd, 2), 2'h0})
        else $error("status fields wrong");
    chk_ctrl_low: assert property (clk_en && reg_rd && reg_addr == GPCFG_GIG_CTRL_OFS
        |-> ##2 reg_rdata[6:0] == 7'h00 && reg_rdata[15:13] == $past(test_mode, 2))
        else $error("control read wrong");
endmodule
bind gpcfg_regs gpcfg_regs_properties gpcfg_regs_properties_inst (.*);

// ### testbench/gpcfg_regs_tb_top.sv
// Purpose: self-checking bench of the gigabit register slice
// Assumes: model drives strobes on the falling edge
// Notes: random values from a fixed seed
`timescale 1ns/1ps
module gpcfg_regs_tb_top;
    import gpcfg_pkg::*;
    logic sys_clk = 0, resetn = 0, clk_en = 1, ms_fault = 0, ms_resolved_master = 0;
    logic local_rx_ok = 0, remote_rx_ok = 0, lp_gig_fd = 0, lp_gig_hd = 0;
    logic idle_err = 0, link_down = 0, reg_rd, reg_wr, reg_rvalid, ms_manual_en;
    logic ms_force_master, adv_multi_port, adv_gig_fd, adv_gig_hd, cable_test_start;
    logic [2:0] test_mode;
    logic [4:0] reg_addr, lv;
    logic [15:0] reg_wdata, reg_rdata, d, v, a, b, p;
    int errors = 0, n_checks = 0, cyc = 0;
    gpcfg_regs gpcfg_regs_inst (.*);
    gpcfg_mgr_model gpcfg_mgr_model_inst (.*);
    initial begin
        forever #4 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc > 5000) begin
            errors++;
            wrap_up();
        end
    end
    task wrap_up;
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
        n_checks++;
        if (s !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    task w(input logic [4:0] ad, input logic [15:0] dd);
        gpcfg_mgr_model_inst.wr(ad, dd);
    endtask
    task r(input logic [4:0] ad);
        gpcfg_mgr_model_inst.rd(ad, v);
    endtask
    task setfn(input logic [1:0] fn);
        w(GPCFG_IND_CTRL_OFS, {fn, 9'h000, 5'h1f});
    endtask
    function automatic logic [15:0] exp_stat(input logic f, input logic [7:0] c);
        return {f, lv, 2'h0, c};
    endfunction
    initial begin
        void'($urandom(32'he123));
        repeat (3) @(negedge sys_clk);
        resetn = 1'b1;
        r(GPCFG_GIG_CTRL_OFS);
        chk("ctrl_rst", v, 16'h0300);
        r(5'h03);
        chk("unmapped", v, 16'h0000);
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            d = 16'($urandom);
            d[15:13] = i[2:0];
            ms_resolved_master = 1'($urandom);
            w(GPCFG_GIG_CTRL_OFS, d);
            r(GPCFG_GIG_CTRL_OFS);
            chk("ctrl_rd", v, d & 16'hff80);
            chk("ctrl_out", {9'h000, test_mode, ms_manual_en,
                adv_multi_port, adv_gig_fd, adv_gig_hd}, {9'h000, d[15:12], d[10:8]});
            chk("role", {15'h0000, ms_force_master},
                {15'h0000, d[12] ? d[11] : ms_resolved_master});
        end
        // write strobe while frozen must be lost
        clk_en = 1'b0;
        w(GPCFG_GIG_CTRL_OFS, 16'h0000);
        clk_en = 1'b1;
        r(GPCFG_GIG_CTRL_OFS);
        chk("frozen", v, d & 16'hff80);
        $display("test control done");
        for (int e = 1; e >= 0; e--) begin
            w(GPCFG_GIG_CTRL_OFS, e ? 16'h0380 : 16'h0300);
            @(negedge sys_clk) link_down = 1'b1;
            @(negedge sys_clk) link_down = 1'b0;
            chk("cable_start", {15'h0000, cable_test_start}, e[15:0]);
        end
        $display("test cable done");
        lv = 5'($urandom);
        {ms_resolved_master, local_rx_ok, remote_rx_ok, lp_gig_fd, lp_gig_hd} = lv;
        r(GPCFG_GIG_STAT_OFS);
        @(negedge sys_clk) ms_fault = 1'b1;
        @(negedge sys_clk) ms_fault = 1'b0;
        repeat (260) begin
            @(negedge sys_clk) idle_err = 1'b1;
            @(negedge sys_clk) idle_err = 1'b0;
        end
        r(GPCFG_GIG_STAT_OFS);
        chk("stat_sat", v, exp_stat(1'b1, 8'hff));
        repeat (3) begin
            @(negedge sys_clk) idle_err = 1'b1;
            @(negedge sys_clk) idle_err = 1'b0;
        end
        fork
            r(GPCFG_GIG_STAT_OFS);
            begin
                @(negedge sys_clk) {ms_fault, idle_err} = 2'h3;
                @(negedge sys_clk) {ms_fault, idle_err} = 2'h0;
            end
        join
        chk("stat_cnt", v & 16'h7fff, exp_stat(1'b0, 8'h03));
        r(GPCFG_GIG_STAT_OFS);
        chk("stat_race", v, exp_stat(1'b1, 8'h01));
        r(GPCFG_GIG_STAT_OFS);
        chk("stat_clr", v, exp_stat(1'b0, 8'h00));
        $display("test status done");
        p = {11'h000, 5'($urandom)};
        a = 16'($urandom);
        b = 16'($urandom);
        setfn(2'h0);
        w(GPCFG_IND_DATA_OFS, p);
        setfn(2'h3);
        w(GPCFG_IND_DATA_OFS, a);
        w(GPCFG_IND_DATA_OFS, b);
        setfn(2'h0);
        r(GPCFG_IND_DATA_OFS);
        chk("ptr_wr_inc", v, p + 16'h0002);
        w(GPCFG_IND_DATA_OFS, p);
        setfn(2'h3);
        r(GPCFG_IND_DATA_OFS);
        r(GPCFG_IND_DATA_OFS);
        chk("fn3_read", v, a);
        setfn(2'h1);
        r(GPCFG_IND_DATA_OFS);
        r(GPCFG_IND_DATA_OFS);
        chk("fn1_read", v, a);
        setfn(2'h2);
        r(GPCFG_IND_DATA_OFS);
        chk("fn2_first", v, a);
        r(GPCFG_IND_DATA_OFS);
        chk("fn2_next", v, b);
        w(GPCFG_IND_CTRL_OFS, 16'h7ffe);
        r(GPCFG_IND_CTRL_OFS);
        chk("ind_ctrl", v, 16'h401e);
        w(GPCFG_IND_DATA_OFS, ~a);
        r(GPCFG_IND_DATA_OFS);
        chk("bad_unit", v, 16'h0000);
        setfn(2'h0);
        r(GPCFG_IND_DATA_OFS);
        chk("ptr_after", v, p + 16'h0002);
        w(GPCFG_IND_DATA_OFS, p);
        setfn(2'h1);
        r(GPCFG_IND_DATA_OFS);
        chk("ext_kept", v, a);
        $display("test indirect done");
        wrap_up();
    end
endmodule
